// *** hw/wrf_pkg.sv ***
// package: constants and types of the windowed register file
package wrf_pkg;
  // window organisation
  localparam int WRF_WINDOW_COUNT = 8;
  localparam int WRF_REGS_PER_WIN = 16;
  localparam int WRF_GLOBAL_COUNT = 8;
  localparam int WRF_PHYS_WORDS = 136;
  localparam int WRF_DATA_W = 32;
  localparam int WRF_PHYS_AW = 8;
  // architectural address groups inside the 32-entry space
  localparam logic [4:0] WRF_OUT_BASE = 5'h08;
  localparam logic [4:0] WRF_LOCAL_BASE = 5'h10;
  localparam logic [4:0] WRF_IN_BASE = 5'h18;
  localparam logic [WRF_PHYS_AW-1:0] WRF_WIN_PHYS_BASE = 8'h08;
  // trap vector layout: base field, type field, fixed low bits
  localparam int WRF_TBA_LSB = 12;
  localparam int WRF_TBA_W = 20;
  localparam int WRF_TT_LSB = 4;
  localparam int WRF_TT_W = 8;
  localparam logic [3:0] WRF_VEC_LOW = 4'h0;
  // trap type codes
  localparam logic [7:0] WRF_TT_PRIV = 8'h03;
  localparam logic [7:0] WRF_TT_IRQ_BASE = 8'h10;
  localparam logic [7:0] WRF_TT_SW_BASE = 8'h80;
  // reset values of the processor state word
  localparam logic [2:0] WRF_RST_WINDOW = 3'h0;
  localparam logic WRF_RST_SUP = 1'b1;
  localparam logic WRF_RST_PREV_SUP = 1'b1;
  localparam logic WRF_RST_TRAP_EN = 1'b0;
  localparam logic [3:0] WRF_RST_PIL = 4'h0;
  localparam logic [19:0] WRF_RST_TBA = 20'h00000;
  localparam logic [7:0] WRF_RST_TT = 8'h00;

  // core run state
  typedef enum logic [0:0] {
    WRF_RUN,
    WRF_HALTED
  } wrf_run_t;
endpackage

// *** hw/wrf_mem.sv ***
// three-port working register store: two registered reads, one write
`timescale 1ns/10ps
`default_nettype none
module wrf_mem
  import wrf_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic [WRF_PHYS_AW-1:0] raddr_a, // physical read address a
  input wire logic [WRF_PHYS_AW-1:0] raddr_b, // physical read address b
  input wire logic wen, // write strobe
  input wire logic [WRF_PHYS_AW-1:0] waddr, // physical write address
  input wire logic [WRF_DATA_W-1:0] wdata, // write data
  output logic [WRF_DATA_W-1:0] rdata_a, // registered read data a
  output logic [WRF_DATA_W-1:0] rdata_b // registered read data b
);
  typedef struct packed {
    logic [WRF_DATA_W-1:0] rd_a;
    logic [WRF_DATA_W-1:0] rd_b;
  } wrf_mem_state_t;

  logic [WRF_DATA_W-1:0] store_q [WRF_PHYS_WORDS];
  wrf_mem_state_t s_q;
  wrf_mem_state_t s_d;

  // reads see the old word on a same-cycle write
  always_comb begin
    s_d = s_q;
    s_d.rd_a = store_q[raddr_a];
    s_d.rd_b = store_q[raddr_b];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage array kept unreset so it maps onto a ram
  always_ff @(posedge clk) begin
    if (wen) begin
      store_q[waddr] <= wdata;
    end
  end

  assign rdata_a = s_q.rd_a;
  assign rdata_b = s_q.rd_b;
endmodule
`default_nettype wire

// *** hw/wrf_top.sv ***
// windowed register file with window index, privilege and trap vectoring
// Behaviour
// - 136x32 store, three ports, eight windows
// - 24 windowed registers plus 8 shared globals
// - current window index selects active window
// - call decrements index, return increments it
// - ins, outs, locals; locals private per window
// - previous outs are current ins, physically
// - same globals reachable from every window
// - windows form a ring, last joins first
// - privileged work only in supervisor mode
// - supervisor entered only through a trap
// - interrupts plus error and instruction traps
// - vector is trap base plus type offset
// - trapped instruction changes no visible state
// - save decrements; restore, trap return increment
// - ins equal outs plus sixteen: the outs one window on
`timescale 1ns/10ps
`default_nettype none
module wrf_top
  import wrf_pkg::*;
(
  input wire logic clk, // core clock, 125 MHz
  input wire logic rst_b, // async reset, active low
  // read ports, data one cycle after the address
  input wire logic [4:0] rd_a_addr, // architectural read address a
  input wire logic [4:0] rd_b_addr, // architectural read address b
  output logic [WRF_DATA_W-1:0] rd_a_data, // read data a, one cycle later
  output logic [WRF_DATA_W-1:0] rd_b_data, // read data b, one cycle later
  // write port, dropped in any trapped cycle
  input wire logic wr_en, // register write strobe
  input wire logic [4:0] wr_addr, // architectural write address
  input wire logic [WRF_DATA_W-1:0] wr_data, // register write data
  // window moves from the pipeline
  input wire logic save_req, // call or save: move to next window
  input wire logic restore_req, // return or restore: previous window
  input wire logic trap_return_req, // return from trap handler
  input wire logic priv_instr, // current instruction is privileged
  // state word and trap base writes, privileged
  input wire logic psr_wr_en, // write processor state word
  input wire logic [2:0] psr_wr_window, // new window index
  input wire logic psr_wr_sup, // new supervisor bit
  input wire logic psr_wr_prev_sup, // new previous supervisor bit
  input wire logic psr_wr_trap_en, // new trap enable bit
  input wire logic [3:0] psr_wr_pil, // new interrupt level mask
  input wire logic tbr_wr_en, // write trap base
  input wire logic [WRF_TBA_W-1:0] tbr_wr_base, // new trap base field
  // trap sources; the interrupt pins are asynchronous
  input wire logic err_trap_req, // error condition in current instruction
  input wire logic [7:0] err_trap_type, // trap type of the error
  input wire logic sw_trap_req, // trap instruction executing
  input wire logic [6:0] sw_trap_num, // software trap number
  input wire logic irq_req, // external interrupt request pin
  input wire logic [3:0] irq_level, // external interrupt level pins
  // trap response and processor state
  output logic instr_squash, // current instruction is cancelled
  output logic trap_taken, // pulse: trap entered last cycle
  output logic [WRF_DATA_W-1:0] trap_target, // handler address
  output logic [7:0] trap_type, // type of the last trap
  output logic [2:0] current_window_index, // active window
  output logic supervisor, // supervisor mode
  output logic prev_supervisor, // mode before the last trap
  output logic traps_enabled, // trap enable bit
  output logic [3:0] int_level_mask, // processor interrupt level
  output logic core_halted // synchronous trap with traps disabled
);
  typedef struct packed {
    // processor state word
    wrf_run_t run;
    logic [2:0] win;
    logic sup;
    logic prev_sup;
    logic trap_en;
    logic [3:0] pil;
    // trap base and the last trap taken
    logic [WRF_TBA_W-1:0] tba;
    logic [WRF_TT_W-1:0] tt;
    logic taken;
    logic [WRF_DATA_W-1:0] target;
    // two-flop synchroniser of the interrupt pins
    logic [4:0] irq_s1;
    logic [4:0] irq_s2;
  } wrf_state_t;

  wrf_state_t s_q;
  wrf_state_t s_d;

  logic [WRF_PHYS_AW-1:0] phys_rd_a;
  logic [WRF_PHYS_AW-1:0] phys_rd_b;
  logic [WRF_PHYS_AW-1:0] phys_wr;
  logic mem_wen;
  logic priv_fault;
  logic irq_accept;
  logic sync_trap;
  logic any_trap;
  logic [WRF_TT_W-1:0] tt_sel;
  logic irq_pend;
  // decoded one-cycle actions
  logic win_dec;
  logic win_inc;
  logic ret_load;
  logic psr_load;
  logic tbr_load;
  // handler address of a trap taken this cycle
  logic [WRF_DATA_W-1:0] vec_addr;

  // architectural address to physical word; adding w*16 modulo 128
  // overlaps ins of window w with outs of window w+1 and closes the ring
  // physical layout of the store:
  //   0-7     globals, shared by every window
  //   8+16w   outs of window w, eight words
  //   16+16w  locals of window w, private
  //   24+16w  ins of window w, the outs of window w+1
  //   ins of window 7 fold back onto 8-15, the outs of window 0
  function automatic logic [WRF_PHYS_AW-1:0] phys_of(input logic [4:0] a,
                                                     input logic [2:0] w);
    logic [6:0] off;
    // window-relative offset, wrapped at 128 words
    off = '0;
    if (a < WRF_OUT_BASE) begin
      phys_of = {3'h0, a};
    end else begin
      off = {w, 4'h0} + {2'h0, a - WRF_OUT_BASE};
      phys_of = WRF_WIN_PHYS_BASE + {1'b0, off};
    end
  endfunction

  // all three ports mapped through the same window index
  always_comb begin
    // globals ignore the window index entirely
    phys_rd_a = phys_of(rd_a_addr, s_q.win);
    phys_rd_b = phys_of(rd_b_addr, s_q.win);
    phys_wr = phys_of(wr_addr, s_q.win);
  end

  // trap detection; interrupts are only sampled after synchronising
  // privileged: state word and trap base writes, trap return, flagged work
  always_comb begin
    priv_fault = !s_q.sup && (priv_instr || psr_wr_en || tbr_wr_en
                              || trap_return_req);
    // level zero means no request even while the request pin stands
    irq_pend = s_q.irq_s2[4] && (s_q.irq_s2[3:0] != 4'h0);
    irq_accept = s_q.trap_en && irq_pend && (s_q.irq_s2[3:0] > s_q.pil);
    sync_trap = err_trap_req || priv_fault || sw_trap_req;
    any_trap = (s_q.run == WRF_RUN) && (sync_trap || irq_accept);
  end

  // synchronous causes outrank the interrupt, which simply waits
  // type priority: error, privilege fault, trap instruction, interrupt
  always_comb begin
    if (err_trap_req) begin
      tt_sel = err_trap_type;
    end else if (priv_fault) begin
      tt_sel = WRF_TT_PRIV;
    end else if (sw_trap_req) begin
      tt_sel = WRF_TT_SW_BASE | {1'b0, sw_trap_num};
    end else begin
      tt_sel = WRF_TT_IRQ_BASE | {4'h0, s_q.irq_s2[3:0]};
    end
  end

  // a trapped instruction never writes: squash the write port too
  // cut here rather than in the store, so the store stays a plain ram
  always_comb begin
    instr_squash = any_trap || (s_q.run != WRF_RUN);
    mem_wen = wr_en && !instr_squash;
  end

  // one move per cycle: a trap or a halt overrides every move, and a
  // save and a restore in the same cycle cancel, so the index holds
  always_comb begin
    win_dec = 1'b0;
    win_inc = 1'b0;
    ret_load = 1'b0;
    psr_load = 1'b0;
    tbr_load = 1'b0;
    if (!instr_squash) begin
      // user-mode attempts never get here: they raise the privilege trap
      tbr_load = tbr_wr_en;
      if (trap_return_req) begin
        ret_load = 1'b1;
      end else if (psr_wr_en) begin
        psr_load = 1'b1;
      end else if (save_req && !restore_req) begin
        win_dec = 1'b1;
      end else if (restore_req && !save_req) begin
        win_inc = 1'b1;
      end
    end
  end

  // handler slots sixteen bytes apart: base, type, four zero bits
  always_comb begin
    vec_addr = {s_q.tba, tt_sel, WRF_VEC_LOW};
  end

  // next state of the processor state word and trap registers
  always_comb begin
    // defaults: hold everything, drop the one-cycle trap pulse
    s_d = s_q;
    s_d.taken = 1'b0;
    // synchroniser shifts every cycle, whatever the run state
    s_d.irq_s1 = {irq_req, irq_level};
    s_d.irq_s2 = s_q.irq_s1;
    unique case (s_q.run)
      WRF_RUN: begin
        if (any_trap) begin
          if (sync_trap && !s_q.trap_en) begin
            // a synchronous trap with traps off would lose the return
            // state of the running handler, so the core stops instead
            s_d.run = WRF_HALTED;
          end else begin
            // trap entry opens a fresh window for the handler
            s_d.win = s_q.win - 3'h1;
            s_d.prev_sup = s_q.sup;
            s_d.sup = 1'b1;
            s_d.trap_en = 1'b0;
            s_d.tt = tt_sel;
            s_d.taken = 1'b1;
            s_d.target = vec_addr;
          end
        end
        if (ret_load) begin
          s_d.win = s_q.win + 3'h1;
          s_d.sup = s_q.prev_sup;
          s_d.trap_en = 1'b1;
        end
        if (psr_load) begin
          // explicit state write; only reached in supervisor mode
          s_d.win = psr_wr_window;
          s_d.sup = psr_wr_sup;
          s_d.prev_sup = psr_wr_prev_sup;
          s_d.trap_en = psr_wr_trap_en;
          s_d.pil = psr_wr_pil;
        end
        if (win_dec) begin
          s_d.win = s_q.win - 3'h1;
        end
        if (win_inc) begin
          s_d.win = s_q.win + 3'h1;
        end
        if (tbr_load) begin
          s_d.tba = tbr_wr_base;
        end
      end
      WRF_HALTED: begin
        // stays until reset; the core must be restarted
        // interrupts, moves and state writes are all ignored here
        s_d.run = WRF_HALTED;
      end
    endcase
  end

  // single state register
  // comes up in supervisor mode with traps off, in window 0
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.run <= WRF_RUN;
      s_q.win <= WRF_RST_WINDOW;
      s_q.sup <= WRF_RST_SUP;
      s_q.prev_sup <= WRF_RST_PREV_SUP;
      s_q.trap_en <= WRF_RST_TRAP_EN;
      s_q.pil <= WRF_RST_PIL;
      s_q.tba <= WRF_RST_TBA;
      s_q.tt <= WRF_RST_TT;
      s_q.taken <= 1'b0;
      s_q.target <= '0;
      s_q.irq_s1 <= '0;
      s_q.irq_s2 <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // three-port physical store
  // reads register inside, so read data trail the address by a cycle
  wrf_mem u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .raddr_a(phys_rd_a),
    .raddr_b(phys_rd_b),
    .wen(mem_wen),
    .waddr(phys_wr),
    .wdata(wr_data),
    .rdata_a(rd_a_data),
    .rdata_b(rd_b_data)
  );

  // state outputs straight from flip-flops
  // trap pulse lasts one cycle; vector and type stand until the next trap
  assign trap_taken = s_q.taken;
  assign trap_target = s_q.target;
  assign trap_type = s_q.tt;
  assign current_window_index = s_q.win;
  assign supervisor = s_q.sup;
  assign prev_supervisor = s_q.prev_sup;
  assign traps_enabled = s_q.trap_en;
  assign int_level_mask = s_q.pil;
  assign core_halted = (s_q.run == WRF_HALTED);
endmodule
`default_nettype wire

// *** bench/wrf_top_asserts.sv ***
// checker: window moves, privilege and trap entry at the top ports
`timescale 1ns/10ps
`default_nettype none
module wrf_chk
  import wrf_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_b, // reset, low
  input wire logic save_req, // save
  input wire logic restore_req, // restore
  input wire logic trap_return_req, // trap return
  input wire logic psr_wr_en, // state write
  input wire logic priv_instr, // privileged
  input wire logic err_trap_req, // error trap
  input wire logic sw_trap_req, // sw trap
  input wire logic [6:0] sw_trap_num, // sw number
  input wire logic instr_squash, // cancel
  input wire logic trap_taken, // trap pulse
  input wire logic [WRF_DATA_W-1:0] trap_target, // vector
  input wire logic [7:0] trap_type, // type
  input wire logic [2:0] current_window_index, // window
  input wire logic supervisor, // mode
  input wire logic prev_supervisor, // old mode
  input wire logic traps_enabled, // enable
  input wire logic core_halted // halt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // sums kept 3 bits wide so the ring wraps as the hardware does
  logic [2:0] cw;
  logic mv_ok;
  assign cw = current_window_index;
  assign mv_ok = !trap_return_req && !psr_wr_en && !instr_squash;
  chk_save_dec: assert property (
    save_req && !restore_req && mv_ok |=> cw + 3'h1 == $past(cw)) else $error("save missed");
  chk_restore_inc: assert property (
    restore_req && !save_req && mv_ok |=> cw == $past(cw) + 3'h1) else $error("restore missed");
  chk_trap_entry: assert property (
    instr_squash && !core_halted && traps_enabled |=> trap_taken && supervisor && !traps_enabled
    && prev_supervisor == $past(supervisor)) else $error("trap entry state wrong");
  chk_trap_window: assert property (
    trap_taken |-> cw + 3'h1 == $past(cw)) else $error("trap window wrong");
  chk_vec_low: assert property (
    trap_taken |-> trap_target[11:0] == {trap_type, WRF_VEC_LOW}) else $error("vector wrong");
  chk_sw_type: assert property (
    sw_trap_req && supervisor && traps_enabled && !err_trap_req && !core_halted
    |=> trap_taken && trap_type == {1'b1, $past(sw_trap_num)}) else $error("sw type wrong");
  chk_priv_trap: assert property (
    !supervisor && priv_instr && traps_enabled && !err_trap_req
    |=> trap_taken && trap_type == WRF_TT_PRIV) else $error("privilege trap missed");
  chk_trap_ret_state: assert property (
    trap_return_req && supervisor && !instr_squash |=> traps_enabled && cw == $past(cw) + 3'h1
    && supervisor == $past(prev_supervisor)) else $error("trap return state wrong");
  chk_halt_hold: assert property (
    core_halted |-> instr_squash ##1 core_halted) else $error("halt not held");
endmodule
bind wrf_top wrf_chk chk_u (.clk, .rst_b, .save_req, .restore_req, .trap_return_req, .psr_wr_en,
  .priv_instr, .err_trap_req, .sw_trap_req, .sw_trap_num, .instr_squash, .trap_taken,
  .trap_target, .trap_type, .current_window_index, .supervisor, .prev_supervisor,
  .traps_enabled, .core_halted);
`default_nettype wire

// *** bench/wrf_irq_src.sv ***
// partner: interrupt pins of the core, held until a trap is entered
`timescale 1ns/10ps
`default_nettype none
module wrf_irq_src (
  input wire logic clk, // core clock
  input wire logic rst_b, // reset, low
  input wire logic raise, // bench asks for an interrupt
  input wire logic [3:0] lvl, // level to present
  input wire logic trap_taken, // core entered a trap
  output logic irq_req, // request pin
  output logic [3:0] irq_level // level pins
);
  // a masked request keeps standing; a newer raise replaces its level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
      irq_level <= 4'h0;
    end else if (raise) begin
      irq_req <= 1'b1;
      irq_level <= lvl;
    end else if (trap_taken) begin
      irq_req <= 1'b0;
      irq_level <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// *** bench/wrf_top_tb.sv ***
// testbench: random register traffic, window moves and trap entry
`timescale 1ns/10ps
`default_nettype none
module wrf_top_tb import wrf_pkg::*;;
  logic clk = 0, rst_b = 0, wr_en = 0, save_req = 0, restore_req = 0, trap_return_req = 0;
  logic priv_instr = 0, psr_wr_en = 0, psr_wr_sup = 0, psr_wr_prev_sup = 0, psr_wr_trap_en = 0;
  logic tbr_wr_en = 0, err_trap_req = 0, sw_trap_req = 0, raise = 0, irq_req, instr_squash;
  logic trap_taken, supervisor, prev_supervisor, traps_enabled, core_halted;
  logic [4:0] rd_a_addr = 0, rd_b_addr = 0, wr_addr = 0;
  logic [2:0] psr_wr_window = 0, current_window_index, cw = 0;
  logic [3:0] psr_wr_pil = 4'h3, lvl = 0, irq_level, int_level_mask;
  logic [6:0] sw_trap_num = 0;
  logic [7:0] err_trap_type = 0, trap_type;
  logic [19:0] tbr_wr_base = 20'hA5C3E;
  logic [31:0] wr_data = 0, rd_a_data, rd_b_data, trap_target, r, mem [136], s = 45;
  bit vld [136];
  int fail_count = 0, cmp_count = 0, cyc = 0;
  always #4 clk = ~clk;
  wrf_top dut_u (.clk, .rst_b, .rd_a_addr, .rd_b_addr, .rd_a_data, .rd_b_data, .wr_en, .wr_addr,
    .wr_data, .save_req, .restore_req, .trap_return_req, .priv_instr, .psr_wr_en, .psr_wr_window,
    .psr_wr_sup, .psr_wr_prev_sup, .psr_wr_trap_en, .psr_wr_pil, .tbr_wr_en, .tbr_wr_base,
    .err_trap_req, .err_trap_type, .sw_trap_req, .sw_trap_num, .irq_req, .irq_level,
    .instr_squash, .trap_taken, .trap_target, .trap_type, .current_window_index, .supervisor,
    .prev_supervisor, .traps_enabled, .int_level_mask, .core_halted);
  wrf_irq_src src_u (.clk, .rst_b, .raise, .lvl, .trap_taken, .irq_req, .irq_level);
  // hang guard: the run needs well under this many cycles
  always @(posedge clk) begin
    if (++cyc == 6000) begin
      fail_count++;
      close_out();
    end
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // bench view of the store: globals flat, windows sixteen apart, overlapping by eight
  function automatic int phys(input logic [2:0] w, input logic [4:0] a);
    return (a < 8) ? int'(a) : 8 + (int'(w) * 16 + int'(a) - 8) % 128;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr_en, wr_addr, wr_data} <= {1'b1, a, d};
    @(posedge clk);
    wr_en <= 1'b0;
    mem[phys(cw, a)] = d;
    vld[phys(cw, a)] = 1;
  endtask
  // store is undefined after reset, so only written words are compared
  task automatic rd(input logic [4:0] a, input logic [4:0] b);
    @(posedge clk);
    {rd_a_addr, rd_b_addr} <= {a, b};
    @(posedge clk);
    #1;
    if (vld[phys(cw, a)]) chk(rd_a_data, mem[phys(cw, a)]);
    if (vld[phys(cw, b)]) chk(rd_b_data, mem[phys(cw, b)]);
  endtask
  // one-cycle request; trapping kinds carry a write that must be dropped
  task automatic pls(input int k, input logic [7:0] v);
    @(posedge clk);
    {save_req, restore_req, trap_return_req, sw_trap_req, err_trap_req, priv_instr} <= 6'h20 >> k;
    {sw_trap_num, err_trap_type} <= {v[6:0], v};
    {wr_en, wr_addr, wr_data} <= {k > 2, 5'h01, 32'hFFFFFFFF};
    @(posedge clk);
    {save_req, restore_req, trap_return_req, sw_trap_req, err_trap_req, priv_instr} <= 6'h00;
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic cfg(input logic [2:0] w, input logic su, pv, te);
    @(posedge clk);
    {psr_wr_window, psr_wr_sup, psr_wr_prev_sup, psr_wr_trap_en} <= {w, su, pv, te};
    {psr_wr_en, tbr_wr_en} <= 2'h3;
    @(posedge clk);
    {psr_wr_en, tbr_wr_en} <= 2'h0;
    #1;
    cw = w;
  endtask
  task automatic st(input logic [2:0] w, input logic su, pv, te);
    chk(current_window_index, w);
    chk(supervisor, su);
    chk(prev_supervisor, pv);
    chk(traps_enabled, te);
  endtask
  task automatic irq(input logic [3:0] l, input logic exp);
    logic seen;
    seen = 0;
    @(posedge clk);
    {raise, lvl} <= {1'b1, l};
    @(posedge clk);
    raise <= 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (trap_taken) begin
        seen = 1;
        chk(trap_type, WRF_TT_IRQ_BASE | {4'h0, l});
      end
    end
    chk(seen, exp);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    st(3'h0, 1, 1, 0);
    chk(rd_a_data, 32'h00000000);
    wr(5'h01, 32'h12345678);
    // ring corner: outs of window 0 are the ins of window 7
    wr(5'h08, 32'h0000C0DE);
    pls(0, 8'h00);
    cw = 3'h7;
    rd(5'h18, 5'h18);
    chk(rd_a_data, 32'h0000C0DE);
    pls(1, 8'h00);
    cw = 3'h0;
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      case (r[1:0])
        2'h0: wr(r[6:2], rnd());
        2'h1: rd(r[6:2], r[11:7]);
        default: begin
          pls(r[8] ? 0 : 1, 8'h00);
          cw = r[8] ? cw - 3'h1 : cw + 3'h1;
          chk(current_window_index, cw);
        end
      endcase
    end
    cfg(3'h5, 1, 0, 1);
    chk(int_level_mask, 4'h3);
    r = rnd();
    pls(3, r[7:0]);
    chk(trap_taken, 1);
    chk(trap_type, {1'b1, r[6:0]});
    chk(trap_target, {20'hA5C3E, 1'b1, r[6:0], 4'h0});
    st(3'h4, 1, 1, 0);
    cw = 3'h4;
    rd(5'h01, 5'h01);
    chk(trap_taken, 0);
    pls(2, 8'h00);
    st(3'h5, 1, 1, 1);
    cfg(3'h2, 0, 0, 1);
    pls(5, 8'h00);
    chk(trap_type, WRF_TT_PRIV);
    st(3'h1, 1, 0, 0);
    pls(2, 8'h00);
    st(3'h2, 0, 0, 1);
    // error trap from user mode, then trap return attempted in user mode
    pls(4, 8'h2A);
    chk(trap_type, 8'h2A);
    chk(trap_target, {20'hA5C3E, 8'h2A, 4'h0});
    st(3'h1, 1, 0, 0);
    pls(2, 8'h00);
    st(3'h2, 0, 0, 1);
    pls(2, 8'h00);
    chk(trap_type, WRF_TT_PRIV);
    st(3'h1, 1, 0, 0);
    pls(2, 8'h00);
    st(3'h2, 0, 0, 1);
    irq(4'h3, 0);
    irq(4'h5, 1);
    pls(4, 8'h2A);
    chk(core_halted, 1);
    chk(trap_taken, 0);
    chk(instr_squash, 1);
    rd(5'h01, 5'h01);
    close_out();
  end
endmodule
`default_nettype wire
